// [inc/epmp_map.vh]
// Constants for the muxed-bus PROM and I/O port block
`ifndef EPMP_MAP_VH
`define EPMP_MAP_VH
`define EPMP_SEL_PORT_A 2'h0
`define EPMP_SEL_PORT_B 2'h1
`define EPMP_SEL_DIR_A 2'h2
`define EPMP_SEL_DIR_B 2'h3
`define EPMP_DIR_RESET 8'h00
`define EPMP_LATCH_RESET 8'h00
`define EPMP_SYNC_RESET 34'h2FFFFFFFF
`define EPMP_ROM_WORDS 2048
`define EPMP_ROM_ERASED 8'hFF
`define EPMP_AVL_CTRL 2'h0
`define EPMP_AVL_STATUS 2'h1
`define EPMP_AVL_ROMADDR 2'h2
`define EPMP_AVL_ROMDATA 2'h3
`define EPMP_AVL_BAD 32'hDEADBEEF
`endif

// [hdl/epmp_rom.v]
// Preloadable 2048 x 8 read-only array with a loader port
`timescale 1ns/1ps
`include "epmp_map.vh"
module epmp_rom
(
  // Clock
  input wire sys_clk,
  // Loader
  input wire load_we,
  input wire [10:0] load_addr,
  input wire [7:0] load_data,
  // Read
  input wire [10:0] rd_addr,
  output wire [7:0] rd_data
);
  reg [7:0] mem_ff [0:`EPMP_ROM_WORDS-1];
  integer i;
  initial
  begin
    for (i = 0; i < `EPMP_ROM_WORDS; i = i + 1)
      mem_ff[i] = `EPMP_ROM_ERASED;
  end
  // Only the image loader writes; reads never modify [R21]
  always @(posedge sys_clk)
  begin
    if (load_we)
      mem_ff[load_addr] <= load_data;
  end
  assign rd_data = mem_ff[rd_addr]; // [R3]
endmodule

// [hdl/epmp_port.v]
// Muxed address/data bus front end of a 2048 x 8 PROM with two 8-bit ports
//
// Behaviour
// R1: Falling latch strobe captures low address, memory/I-O select, high bits, enables.
// R2: Host presents low eight address bits while latch strobe is high.
// R3: Array is 2048 by 8, addressed by latched eleven bits.
// R4: High address bits do not affect port or direction accesses.
// R5: Respond only if enables latched as low-first and high-second.
// R6: Inactive latched enables float the bus and ready outputs.
// R7: Read returns port data when select high, array data when low.
// R8: Drive bus only while read or I/O-read strobe low, enabled.
// R9: Memory read outputs array byte at latched address.
// R10: Low I/O-write writes bus byte to addressed port; select ignored.
// R11: Low I/O-read reads the port like read with select high.
// R12: Port A written when address bits are zero zero.
// R13: Port A read on zero zero address with either read form.
// R14: Port B uses address bit zero one, bit one zero.
// R15: Ready low while enabled during latch strobe high, released next clock.
// R16: Reset clears both direction registers, making all pins inputs.
// R17: Per-port 8-bit write-only direction registers; one means output.
// R18: Address one-zero selects direction A, one-one direction B.
// R19: Port write updates all latch bits; pins change after write strobe rises.
// R20: Latch writable while outputs disabled; reads return all eight bits.
// R21: Array contents are a preloaded image never changed by reads.
`timescale 1ns/1ps
`include "epmp_map.vh"
module epmp_port
(
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Device reset pin, active high
  input wire reset_pin,
  // Host bus pins
  input wire ale,
  input wire io_mem_sel,
  input wire rd_n,
  input wire ior_n,
  input wire iow_n,
  input wire select_low_n,
  input wire select_high,
  input wire [2:0] high_addr_bits,
  input wire [7:0] muxed_addr_data_bus_in,
  output wire [7:0] muxed_addr_data_bus_out,
  output wire muxed_addr_data_bus_oe,
  output wire ready_out,
  output wire ready_oe,
  // Port pins
  input wire [7:0] port_a_pins_in,
  output wire [7:0] port_a_pins_out,
  output wire [7:0] port_a_pins_oe,
  input wire [7:0] port_b_pins_in,
  output wire [7:0] port_b_pins_out,
  output wire [7:0] port_b_pins_oe,
  // Avalon-MM slave for image loading and status
  input wire [1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest
);
  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  localparam NSYNC = 34;
  wire [NSYNC-1:0] raw_in;
  reg [NSYNC-1:0] meta_ff;
  reg [NSYNC-1:0] sync_ff;
  // Strobes reset idle high; the latch strobe resets low so no false fall follows
  assign raw_in = {reset_pin, ale, io_mem_sel, rd_n, ior_n, iow_n, select_low_n,
    select_high, high_addr_bits,
    muxed_addr_data_bus_in, port_a_pins_in,
    port_b_pins_in[6:0]};
  reg pb7_meta_ff;
  reg pb7_ff;
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      meta_ff <= `EPMP_SYNC_RESET;
      sync_ff <= `EPMP_SYNC_RESET;
      pb7_meta_ff <= 1'b0;
      pb7_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= raw_in;
      sync_ff <= meta_ff;
      pb7_meta_ff <= port_b_pins_in[7];
      pb7_ff <= pb7_meta_ff;
    end
  end
  wire s_reset = sync_ff[33];
  wire s_ale = sync_ff[32];
  wire s_iom = sync_ff[31];
  wire s_rd_n = sync_ff[30];
  wire s_ior_n = sync_ff[29];
  wire s_iow_n = sync_ff[28];
  wire s_sel_low_n = sync_ff[27];
  wire s_sel_high = sync_ff[26];
  wire [2:0] s_hi = sync_ff[25:23];
  wire [7:0] s_bus = sync_ff[22:15];
  wire [7:0] s_pa = sync_ff[14:7];
  wire [7:0] s_pb = {pb7_ff, sync_ff[6:0]};
  // ==========================================================
  // Address latch
  // ==========================================================
  reg ale_d_ff;
  reg iow_d_ff;
  reg [7:0] lat_lo_ff;
  reg [2:0] lat_hi_ff;
  reg lat_iom_ff;
  reg lat_en_ff;
  reg ready_low_ff;
  wire ale_fall = ale_d_ff & ~s_ale;
  wire en_now = ~s_sel_low_n & s_sel_high; // [R5]
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      ale_d_ff <= 1'b0;
      iow_d_ff <= 1'b1;
      lat_lo_ff <= `EPMP_LATCH_RESET;
      lat_hi_ff <= 3'h0;
      lat_iom_ff <= 1'b0;
      lat_en_ff <= 1'b0;
      ready_low_ff <= 1'b0;
    end
    else
    begin
      ale_d_ff <= s_ale;
      iow_d_ff <= s_iow_n;
      if (ale_fall)
      begin
        lat_lo_ff <= s_bus; // [R1] [R2]
        lat_hi_ff <= s_hi; // [R1]
        lat_iom_ff <= s_iom; // [R1]
        lat_en_ff <= en_now; // [R1] [R5]
      end
      // Low while enabled during strobe high; the next edge after it ends releases
      ready_low_ff <= s_ale & en_now; // [R15]
    end
  end
  assign ready_out = 1'b0;
  assign ready_oe = ready_low_ff | (s_ale & en_now); // [R15] [R6]
  // ==========================================================
  // Port selection and registers
  // ==========================================================
  wire [1:0] sel = lat_lo_ff[1:0]; // [R4]
  wire io_rd = lat_en_ff & (~s_ior_n | (lat_iom_ff & ~s_rd_n)); // [R11] [R7]
  wire mem_rd = lat_en_ff & ~s_rd_n & ~lat_iom_ff & s_ior_n; // [R9]
  wire io_wr = lat_en_ff & ~s_iow_n; // [R10]
  reg [7:0] latch_a_ff;
  reg [7:0] latch_b_ff;
  reg [7:0] pin_a_ff;
  reg [7:0] pin_b_ff;
  reg [7:0] dir_a_ff;
  reg [7:0] dir_b_ff;
  // Direction registers clear on either reset and are never read back
  always @(posedge sys_clk)
  begin
    if (!rstn || s_reset)
    begin
      dir_a_ff <= `EPMP_DIR_RESET; // [R16]
      dir_b_ff <= `EPMP_DIR_RESET; // [R16]
    end
    else if (io_wr)
    begin
      if (sel == `EPMP_SEL_DIR_A)
        dir_a_ff <= s_bus; // [R17] [R18]
      if (sel == `EPMP_SEL_DIR_B)
        dir_b_ff <= s_bus; // [R17] [R18]
    end
  end
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      latch_a_ff <= `EPMP_LATCH_RESET;
      latch_b_ff <= `EPMP_LATCH_RESET;
      pin_a_ff <= `EPMP_LATCH_RESET;
      pin_b_ff <= `EPMP_LATCH_RESET;
    end
    else
    begin
      if (io_wr && sel == `EPMP_SEL_PORT_A)
        latch_a_ff <= s_bus; // [R12] [R19] [R20]
      if (io_wr && sel == `EPMP_SEL_PORT_B)
        latch_b_ff <= s_bus; // [R14] [R19] [R20]
      // Pins follow the latch only once the write strobe has risen
      if (s_iow_n && iow_d_ff)
      begin
        pin_a_ff <= latch_a_ff; // [R19]
        pin_b_ff <= latch_b_ff; // [R19]
      end
    end
  end
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_pin
      assign port_a_pins_out[g] = pin_a_ff[g];
      assign port_a_pins_oe[g] = dir_a_ff[g]; // [R17]
      assign port_b_pins_out[g] = pin_b_ff[g];
      assign port_b_pins_oe[g] = dir_b_ff[g]; // [R17]
    end
  endgenerate
  // ==========================================================
  // Array and bus read
  // ==========================================================
  wire load_we = avs_write && avs_address == `EPMP_AVL_ROMDATA;
  reg [10:0] load_addr_ff;
  reg ctrl_ff;
  wire [7:0] rom_q;
  wire [10:0] rom_addr = {lat_hi_ff, lat_lo_ff}; // [R3]
  epmp_rom i_epmp_rom
  (
    .sys_clk(sys_clk),
    .load_we(load_we),
    .load_addr(load_addr_ff),
    .load_data(avs_writedata[7:0]),
    .rd_addr(rom_addr),
    .rd_data(rom_q)
  );
  reg [7:0] rd_data_ff;
  reg drive_ff;
  wire rd_any = io_rd | mem_rd; // [R8]
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      rd_data_ff <= 8'h00;
      drive_ff <= 1'b0;
    end
    else
    begin
      drive_ff <= rd_any & ~ctrl_ff; // [R8] [R6]
      if (io_rd)
      begin
        // Both input and output bits read back; direction registers never read
        if (sel == `EPMP_SEL_PORT_A)
          rd_data_ff <= s_pa; // [R13] [R20]
        else if (sel == `EPMP_SEL_PORT_B)
          rd_data_ff <= s_pb; // [R14] [R20]
        else
          rd_data_ff <= 8'h00; // [R17]
      end
      else if (mem_rd)
        rd_data_ff <= rom_q; // [R7] [R9]
    end
  end
  assign muxed_addr_data_bus_out = rd_data_ff;
  assign muxed_addr_data_bus_oe = drive_ff & rd_any; // [R8]
  // ==========================================================
  // Avalon-MM slave
  // ==========================================================
  reg rd_wait_ff;
  reg [31:0] nxt_avs_readdata;
  // A read waits one cycle so that its data come from a register
  wire rd_take = avs_read & ~rd_wait_ff;
  assign avs_waitrequest = rd_take;
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      ctrl_ff <= 1'b0;
      load_addr_ff <= 11'h000;
      rd_wait_ff <= 1'b0;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      rd_wait_ff <= rd_take;
      if (rd_take)
        avs_readdata <= nxt_avs_readdata;
      if (avs_write)
      begin
        if (avs_address == `EPMP_AVL_CTRL)
          ctrl_ff <= avs_writedata[0];
        else if (avs_address == `EPMP_AVL_ROMADDR)
          load_addr_ff <= avs_writedata[10:0];
        else if (load_we)
          load_addr_ff <= load_addr_ff + 11'h001;
      end
    end
  end
  // ==========================================================
  // Avalon-MM read data
  // ==========================================================
  always @*
  begin
    case (avs_address)
      `EPMP_AVL_CTRL: nxt_avs_readdata = {31'h0, ctrl_ff};
      `EPMP_AVL_STATUS: nxt_avs_readdata = {21'h0, lat_en_ff, lat_iom_ff,
        dir_a_ff == 8'h00, dir_b_ff == 8'h00,
        ready_oe, muxed_addr_data_bus_oe, sel, 3'h0};
      `EPMP_AVL_ROMADDR: nxt_avs_readdata = {21'h0, load_addr_ff};
      default: nxt_avs_readdata = {24'h0, rom_q};
    endcase
  end
endmodule

// [bench/epmp_host_model.sv]
// Host processor model for the muxed address/data bus
`timescale 1ns/1ps
module epmp_host_model
(
  // Clock and device answer
  input wire sys_clk,
  input wire [7:0] muxed_addr_data_bus_out,
  input wire muxed_addr_data_bus_oe,
  // Bus pins
  output logic ale, io_mem_sel, rd_n, ior_n, iow_n, select_low_n, select_high, bus_en,
  output logic [2:0] high_addr_bits,
  output logic [7:0] bus_drv
);
  // ========
  // Bus cycle: op 0 memory read, 1 I/O read, 2 read with I/O select, 3 I/O write
  initial
  begin
    {ale, io_mem_sel, rd_n, ior_n, iow_n, select_low_n, select_high, bus_en} = 8'h3C;
    {high_addr_bits, bus_drv} = 11'h000;
  end
  task automatic cyc(input logic [1:0] op, input logic [1:0] en, input logic [10:0] a,
    input logic [7:0] d, output logic [7:0] got, output logic drv);
    {ale, bus_en, high_addr_bits, bus_drv} <= {2'h3, a};
    {io_mem_sel, select_low_n, select_high} <= {op != 2'h0, en};
    repeat (4) @(posedge sys_clk);
    ale <= 1'b0;
    repeat (4) @(posedge sys_clk);
    {bus_en, bus_drv} <= {op == 2'h3, d};
    {rd_n, ior_n, iow_n} <= {op[0], op != 2'h1, op != 2'h3};
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    got = muxed_addr_data_bus_out;
    drv = muxed_addr_data_bus_oe;
    @(posedge sys_clk);
    {rd_n, ior_n, iow_n, bus_en} <= 4'hE;
    repeat (5) @(posedge sys_clk);
  endtask
endmodule

// [bench/epmp_port_assertions.sv]
// Checker for the pin behaviour of the muxed-bus PROM port block
`timescale 1ns/1ps
module epmp_port_assertions
(
  // Clock and reset
  input logic sys_clk, rstn,
  // Watched pins
  input logic reset_pin, ale, rd_n, ior_n, iow_n, select_low_n, select_high,
  input logic muxed_addr_data_bus_oe, ready_out, ready_oe,
  input logic [7:0] port_a_pins_out, port_a_pins_oe, port_b_pins_out, port_b_pins_oe
);
  // ========
  // Bus, ready and port timing
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  sequence s_latch;
    (ale && !select_low_n && select_high)[*4] ##1 (!ale)[*4];
  endsequence
  sequence s_rd;
    (!rd_n && iow_n)[*6];
  endsequence
  AST_READ_ANSWER: assert property (s_latch ##1 s_rd |-> muxed_addr_data_bus_oe)
    else $error("Enabled read not answered");
  AST_BUS_IDLE: assert property ((rd_n && ior_n)[*4] |-> !muxed_addr_data_bus_oe)
    else $error("Bus driven with strobes high");
  AST_READY_ASSERT: assert property ($rose(ale) && !select_low_n && select_high |-> ##[1:3] ready_oe)
    else $error("Ready not driven");
  AST_READY_RELEASE: assert property ((!ale)[*4] |-> !ready_oe)
    else $error("Ready not released");
  AST_READY_REFUSE: assert property ((select_low_n || !select_high)[*4] |-> !ready_oe)
    else $error("Ready driven while disabled");
  AST_READY_LEVEL: assert property (ready_oe |-> !ready_out)
    else $error("Ready not low");
  AST_DIR_RESET: assert property (reset_pin[*4] |-> {port_a_pins_oe, port_b_pins_oe} == 16'h0)
    else $error("Directions not cleared");
  AST_PIN_HOLD: assert property ((!iow_n)[*3] |-> $stable({port_a_pins_out, port_b_pins_out}))
    else $error("Pins changed during write");
endmodule
bind epmp_port epmp_port_assertions i_epmp_port_assertions (.*);

// [bench/test_eprom_io_muxed_bus_port.sv]
// Self-checking bench for the muxed-bus PROM and port block
`timescale 1ns/1ps
`include "epmp_map.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_eprom_io_muxed_bus_port;
  typedef struct packed {logic [1:0] op, en; logic [10:0] a; logic [7:0] d, e; logic v;} epmp_row_t;
  logic sys_clk = 1'b0, rstn = 1'b0, reset_pin = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic ale, io_mem_sel, rd_n, ior_n, iow_n, select_low_n, select_high, bus_en, drv, rdy_seen;
  logic muxed_addr_data_bus_oe, ready_out, ready_oe, avs_waitrequest;
  logic [2:0] high_addr_bits;
  logic [7:0] bus_drv, muxed_addr_data_bus_out, got;
  logic [7:0] port_a_pins_out, port_a_pins_oe, port_b_pins_out, port_b_pins_oe;
  logic [1:0] avs_address = 2'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  int checks = 0;
  int mismatches = 0;
  epmp_row_t rows [12];
  wire [7:0] muxed_addr_data_bus_in = muxed_addr_data_bus_oe ? muxed_addr_data_bus_out
    : (bus_en ? bus_drv : ~bus_drv);
  wire [7:0] port_a_pins_in = (port_a_pins_oe & port_a_pins_out) | (~port_a_pins_oe & 8'hC3);
  wire [7:0] port_b_pins_in = (port_b_pins_oe & port_b_pins_out) | (~port_b_pins_oe & 8'hA5);
  epmp_port i_epmp_port (.*);
  epmp_host_model i_epmp_host_model (.*);
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (ready_oe === 1'b1) rdy_seen <= 1'b1;
  // ========
  // Tasks
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic hang;
    mismatches++;
    final_report;
  endtask
  task automatic av(input logic wr, input logic [1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {avs_read, avs_write, avs_address, avs_writedata} <= {!wr, wr, a, d};
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0 && ++n < 20);
    q = avs_readdata;
    {avs_read, avs_write} <= 2'h0;
    @(posedge sys_clk);
    if (n == 20)
      hang;
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    hang;
  end
  initial
  begin
    rows = '{{2'h0, 2'h1, 11'h7FF, 8'h00, 8'h5A, 1'b1},
      {2'h0, 2'h1, 11'h003, 8'h00, 8'hC3, 1'b1},
      {2'h3, 2'h1, 11'h502, 8'hFF, 8'h00, 1'b0},
      {2'h3, 2'h1, 11'h700, 8'h3C, 8'h00, 1'b0},
      {2'h1, 2'h1, 11'h600, 8'h00, 8'h3C, 1'b1},
      {2'h3, 2'h1, 11'h003, 8'h0F, 8'h00, 1'b0},
      {2'h3, 2'h1, 11'h001, 8'h96, 8'h00, 1'b0},
      {2'h2, 2'h1, 11'h001, 8'h00, 8'hA6, 1'b1},
      {2'h2, 2'h1, 11'h002, 8'h00, 8'h00, 1'b1},
      {2'h0, 2'h3, 11'h7FF, 8'h00, 8'h00, 1'b0},
      {2'h3, 2'h0, 11'h000, 8'hFF, 8'h00, 1'b0},
      {2'h1, 2'h1, 11'h000, 8'h00, 8'h3C, 1'b1}};
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    @(negedge sys_clk);
    `CHK("reset", 18'h0, {muxed_addr_data_bus_oe, ready_oe, port_a_pins_oe, port_b_pins_oe})
    $display("reset test done");
    @(posedge sys_clk);
    av(1'b1, `EPMP_AVL_ROMADDR, 32'h7FF);
    av(1'b1, `EPMP_AVL_ROMDATA, 32'h5A);
    av(1'b1, `EPMP_AVL_ROMADDR, 32'h3);
    av(1'b1, `EPMP_AVL_ROMDATA, 32'hC3);
    for (int i = 0; i < 12; i++)
    begin
      rdy_seen = 1'b0;
      i_epmp_host_model.cyc(rows[i].op, rows[i].en, rows[i].a, rows[i].d, got, drv);
      `CHK("drive", rows[i].v, drv)
      if (rows[i].v)
        `CHK("data", rows[i].e, got)
      `CHK("ready", rows[i].en == 2'h1, rdy_seen)
      $display("row %0d done", i);
    end
    `CHK("dirs", 16'hFF0F, {port_a_pins_oe, port_b_pins_oe})
    fork
      i_epmp_host_model.cyc(2'h3, 2'h1, 11'h000, 8'h55, got, drv);
      begin
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK("pin hold", 8'h3C, port_a_pins_out)
      end
    join
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("pin new", 8'h55, port_a_pins_out)
    @(posedge sys_clk);
    av(1'b0, `EPMP_AVL_ROMDATA, 32'h0);
    `CHK("image", 8'hFF, q[7:0])
    $display("write and image test done");
    av(1'b1, `EPMP_AVL_CTRL, 32'h1);
    av(1'b0, `EPMP_AVL_CTRL, 32'h0);
    `CHK("ctrl", 32'h1, q)
    i_epmp_host_model.cyc(2'h1, 2'h1, 11'h000, 8'h00, got, drv);
    `CHK("ctrl quiet", 1'b0, drv)
    av(1'b1, `EPMP_AVL_CTRL, 32'h0);
    av(1'b0, `EPMP_AVL_ROMADDR, 32'h0);
    `CHK("romaddr", 32'h4, q)
    $display("control test done");
    reset_pin <= 1'b1;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("dir clear", 16'h0, {port_a_pins_oe, port_b_pins_oe})
    $display("reset pin test done");
    final_report;
  end
endmodule
